// ==== hw/bdc_pkg.sv ====
// constants, field layout and types of the converter and dimming control
// assumes one 125 mhz main clock and an 8-bit register port
package bdc_pkg;

  ////////////////////////////////////////////////////////////////////////
  // clock and timing
  localparam int unsigned MCLK_HZ       = 125_000_000;
  localparam int unsigned MCLK_KHZ      = MCLK_HZ / 1000;
  localparam int unsigned MCLK_MHZ      = MCLK_HZ / 1_000_000;
  localparam int unsigned SC_DETECT_MS  = 15;
  localparam int unsigned COOL_DOWN_MS  = 120;
  localparam int unsigned SS_STEP_NS    = 4000;
  localparam int unsigned SC_DETECT_CYC = SC_DETECT_MS * MCLK_KHZ;
  localparam int unsigned COOL_DOWN_CYC = COOL_DOWN_MS * MCLK_KHZ;
  localparam int unsigned SS_STEP_CYC   = (SS_STEP_NS * MCLK_MHZ + 999) / 1000;
  localparam int          TMR_W         = 24;

  ////////////////////////////////////////////////////////////////////////
  // register port and offsets
  localparam int          ADDR_W          = 8;
  localparam int          DATA_W          = 8;
  localparam logic [7:0]  ADDR_POWER_CTRL = 8'h04;
  localparam logic [7:0]  ADDR_RISE_FLAGS = 8'h07;
  localparam logic [7:0]  ADDR_RISE_MASK  = 8'h0b;
  localparam logic [7:0]  ADDR_DIM_LEVEL  = 8'h20;
  localparam logic [7:0]  ADDR_SLOPE      = 8'h21;
  localparam logic [7:0]  ADDR_AUX_VSEL   = 8'h6e;

  ////////////////////////////////////////////////////////////////////////
  // fields
  localparam int          CONV_AUX      = 0;
  localparam int          CONV_LED      = 1;
  localparam int          NUM_CONV      = 2;
  localparam int          CTRL_AUX_BIT  = 0;
  localparam int          CTRL_LED_BIT  = 1;
  localparam int          FLAG_AUX_BIT  = 0;
  localparam int          FLAG_LED_BIT  = 1;
  localparam int          VSEL_W        = 3;
  localparam int          DIM_CODE_W    = 7;
  localparam int          DIM_EN_BIT    = 7;
  localparam int          SLOPE_W       = 2;
  localparam int          SLOPE_LO_LSB  = 0;
  localparam int          SLOPE_HI_LSB  = 2;
  localparam int          SS_W          = 8;
  localparam int          MV_W          = 16;
  localparam int          SLP_W         = 10;
  localparam logic [7:0]  SS_FULL       = 8'hff;

  ////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [7:0]  CTRL_RST      = 8'h00;
  localparam logic [7:0]  MASK_RST      = 8'h00;
  localparam logic [7:0]  FLAGS_RST     = 8'h00;
  localparam logic [2:0]  VSEL_RST      = 3'h2;
  localparam logic [7:0]  DIM_RST       = 8'h00;
  localparam logic [3:0]  SLOPE_RST     = 4'h0;

  ////////////////////////////////////////////////////////////////////////
  // types
  typedef enum logic [2:0] {
    ST_OFF,
    ST_SOFT,
    ST_RUN,
    ST_COOL,
    ST_LATCH
  } bdc_conv_e;

  typedef enum logic [1:0] {
    DIM_SRC_ZERO,
    DIM_SRC_PIN,
    DIM_SRC_DAC
  } bdc_dim_src_e;

endpackage : bdc_pkg

// ==== hw/bdc_core.sv ====
// auxiliary buck and led driver sequencing, fault handling, dimming select
// assumes analog sense inputs are asynchronous and the host uses the
// single-cycle strobe register port
//
// How it works
// RQ1: select code maps to 2.5,10,5,15,3.3,12,7.2,24 volts.
// RQ2: select field resets to the 5 volt code.
// RQ3: host never rewrites the select register while aux is enabled.
// RQ4: control bit 0 enables the auxiliary regulator.
// RQ5: each converter ramps a soft-start level after enable.
// RQ6: output low for 15 ms shuts down only that converter.
// RQ7: short-circuit shutdown restarts by itself after 120 ms.
// RQ8: excessive on-state drain-source voltage latches the converter off.
// RQ9: aux latch-off sets the aux fault flag at 0x07.
// RQ10: unmasked aux fault flag drives the interrupt pin low.
// RQ11: led driver switches only while its enable bit is set.
// RQ12: gate pin low selects the zero-current level.
// RQ13: gate pin high selects the analog dim pin.
// RQ14: internal dim enable selects the 7-bit dac instead.
// RQ15: dac output is reference times code plus one over 128.
// RQ16: external gate signal stays below about 1 to 2 khz.
// RQ17: low-duty slope codes give 0.1 to 0.4 v/us.
// RQ18: high-duty slope codes give 0.3,0.4,0.6,0.9 v/us.
// RQ19: both slope fields reset to code zero.
// RQ20: reading the rising status flags clears them.
// RQ21: all timing comes from the single main clock.
// RQ22: latched converter stays off until enable toggles or reset.
//
// Implementation choice: strobed register access.
`timescale 1ns/1ps
module bdc_core #(
  parameter int unsigned SC_DETECT_CYCLES = bdc_pkg::SC_DETECT_CYC,
  parameter int unsigned COOL_DOWN_CYCLES = bdc_pkg::COOL_DOWN_CYC,
  parameter int unsigned SS_STEP_CYCLES   = bdc_pkg::SS_STEP_CYC
) (
  // clock and reset
  input  wire logic                          i_mclk,
  input  wire logic                          i_rst_n,
  // register port
  input  wire logic [bdc_pkg::ADDR_W-1:0]    i_addr,
  input  wire logic [bdc_pkg::DATA_W-1:0]    i_wdata,
  input  wire logic                          i_wr,
  input  wire logic                          i_rd,
  output logic      [bdc_pkg::DATA_W-1:0]    o_rdata,
  // power stage sense, asynchronous
  input  wire logic                          i_aux_undervolt,
  input  wire logic                          i_led_undervolt,
  input  wire logic                          i_aux_desat,
  input  wire logic                          i_led_desat,
  input  wire logic                          i_led_duty_high,
  // dimming gate pin, asynchronous
  input  wire logic                          i_dim_gate,
  // auxiliary regulator
  output logic                               o_aux_run,
  output logic      [bdc_pkg::SS_W-1:0]      o_aux_ss_level,
  output logic      [bdc_pkg::VSEL_W-1:0]    o_aux_out_select,
  output logic      [bdc_pkg::MV_W-1:0]      o_aux_target_mv,
  // led driver
  output logic                               o_led_run,
  output logic      [bdc_pkg::SS_W-1:0]      o_led_ss_level,
  output bdc_pkg::bdc_dim_src_e              o_dim_source,
  output logic      [bdc_pkg::DIM_CODE_W:0]  o_dac_numerator,
  output logic      [bdc_pkg::SLP_W-1:0]     o_low_slope_mv_us,
  output logic      [bdc_pkg::SLP_W-1:0]     o_high_slope_mv_us,
  output logic      [bdc_pkg::SLP_W-1:0]     o_slope_mv_us,
  // interrupt
  output logic                               o_interrupt_out_n
);
  import bdc_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // decode functions
  function automatic logic [MV_W-1:0] aux_mv(input logic [VSEL_W-1:0] c);
    logic [MV_W-1:0] v;
    v = 16'h09c4;
    unique case (c)
      3'h0: v = 16'h09c4;
      3'h1: v = 16'h2710;
      3'h2: v = 16'h1388;
      3'h3: v = 16'h3a98;
      3'h4: v = 16'h0ce4;
      3'h5: v = 16'h2ee0;
      3'h6: v = 16'h1c20;
      3'h7: v = 16'h5dc0;
    endcase
    return v;
  endfunction : aux_mv

  function automatic logic [SLP_W-1:0] slope_lo(input logic [1:0] c);
    logic [SLP_W-1:0] v;
    v = 10'h064;
    unique case (c)
      2'h0: v = 10'h064;
      2'h1: v = 10'h0c8;
      2'h2: v = 10'h12c;
      2'h3: v = 10'h190;
    endcase
    return v;
  endfunction : slope_lo

  function automatic logic [SLP_W-1:0] slope_hi(input logic [1:0] c);
    logic [SLP_W-1:0] v;
    v = 10'h12c;
    unique case (c)
      2'h0: v = 10'h12c;
      2'h1: v = 10'h190;
      2'h2: v = 10'h258;
      2'h3: v = 10'h384;
    endcase
    return v;
  endfunction : slope_hi

  function automatic logic [DIM_CODE_W:0] dac_num(
    input logic [DIM_CODE_W-1:0] c
  );
    return {1'b0, c} + 8'h01;
  endfunction : dac_num

  ////////////////////////////////////////////////////////////////////////
  // input synchronisers
  localparam int SY_AUX_UV = 0;
  localparam int SY_LED_UV = 1;
  localparam int SY_AUX_DS = 2;
  localparam int SY_LED_DS = 3;
  localparam int SY_DUTY   = 4;
  localparam int SY_GATE   = 5;
  localparam int SY_N      = 6;

  logic [SY_N-1:0] sync1_q;
  logic [SY_N-1:0] sync2_q;

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= {i_dim_gate, i_led_duty_high, i_led_desat, i_aux_desat,
                  i_led_undervolt, i_aux_undervolt};
      sync2_q <= sync1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // registers
  logic [DATA_W-1:0]  ctrl_q;
  logic [DATA_W-1:0]  mask_q;
  logic [DATA_W-1:0]  flags_q;
  logic [VSEL_W-1:0]  vsel_q;
  logic [DATA_W-1:0]  dim_q;
  logic [3:0]         slope_q;
  logic               sel_written_q;
  logic               wr_vsel;
  logic               rd_flags;

  assign wr_vsel  = i_wr && (i_addr == ADDR_AUX_VSEL);
  assign rd_flags = i_rd && (i_addr == ADDR_RISE_FLAGS);

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ctrl_q        <= CTRL_RST;
      mask_q        <= MASK_RST;
      vsel_q        <= VSEL_RST; // RQ2
      dim_q         <= DIM_RST;
      slope_q       <= SLOPE_RST; // RQ19
      sel_written_q <= 1'b0;
    end else if (i_wr) begin
      unique case (i_addr)
        ADDR_POWER_CTRL: ctrl_q <= i_wdata;
        ADDR_RISE_MASK:  mask_q <= i_wdata;
        ADDR_DIM_LEVEL:  dim_q <= i_wdata;
        ADDR_SLOPE:      slope_q <= i_wdata[3:0];
        ADDR_AUX_VSEL: begin
          vsel_q        <= i_wdata[VSEL_W-1:0];
          sel_written_q <= 1'b1;
        end
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // converter sequencing
  bdc_conv_e             state_q [NUM_CONV];
  logic [TMR_W-1:0]      tmr_q   [NUM_CONV];
  logic [SS_W-1:0]       lvl_q   [NUM_CONV];
  logic [NUM_CONV-1:0]   conv_en;
  logic [NUM_CONV-1:0]   conv_uv;
  logic [NUM_CONV-1:0]   conv_ds;
  logic [NUM_CONV-1:0]   latch_evt;

  assign conv_en = {ctrl_q[CTRL_LED_BIT], ctrl_q[CTRL_AUX_BIT]}; // RQ4 RQ11
  assign conv_uv = {sync2_q[SY_LED_UV], sync2_q[SY_AUX_UV]};
  assign conv_ds = {sync2_q[SY_LED_DS], sync2_q[SY_AUX_DS]};

  always_comb begin
    for (int c = 0; c < NUM_CONV; c++) begin
      latch_evt[c] = conv_en[c] && conv_ds[c] &&
                     (state_q[c] == ST_SOFT || state_q[c] == ST_RUN); // RQ8
    end
  end

  // timers all run on the main clock
  always_ff @(posedge i_mclk or negedge i_rst_n) begin // RQ21
    if (!i_rst_n) begin
      for (int c = 0; c < NUM_CONV; c++) begin
        state_q[c] <= ST_OFF;
        tmr_q[c]   <= '0;
        lvl_q[c]   <= '0;
      end
    end else begin
      for (int c = 0; c < NUM_CONV; c++) begin
        unique case (state_q[c])
          ST_OFF: begin
            tmr_q[c] <= '0;
            lvl_q[c] <= '0;
            if (conv_en[c]) begin
              state_q[c] <= ST_SOFT;
            end
          end
          ST_SOFT: begin
            if (!conv_en[c]) begin
              state_q[c] <= ST_OFF;
            end else if (latch_evt[c]) begin
              state_q[c] <= ST_LATCH; // RQ8
            end else if (lvl_q[c] == SS_FULL) begin
              state_q[c] <= ST_RUN; // RQ5
              tmr_q[c]   <= '0;
            end else if (tmr_q[c] == TMR_W'(SS_STEP_CYCLES - 1)) begin
              tmr_q[c] <= '0;
              lvl_q[c] <= lvl_q[c] + 8'h01; // RQ5
            end else begin
              tmr_q[c] <= tmr_q[c] + 24'h000001;
            end
          end
          ST_RUN: begin
            if (!conv_en[c]) begin
              state_q[c] <= ST_OFF;
            end else if (latch_evt[c]) begin
              state_q[c] <= ST_LATCH;
            end else if (!conv_uv[c]) begin
              tmr_q[c] <= '0;
            end else if (tmr_q[c] == TMR_W'(SC_DETECT_CYCLES - 1)) begin
              state_q[c] <= ST_COOL; // RQ6
              tmr_q[c]   <= '0;
            end else begin
              tmr_q[c] <= tmr_q[c] + 24'h000001;
            end
          end
          ST_COOL: begin
            if (!conv_en[c]) begin
              state_q[c] <= ST_OFF;
            end else if (tmr_q[c] == TMR_W'(COOL_DOWN_CYCLES - 1)) begin
              state_q[c] <= ST_SOFT; // RQ7
              tmr_q[c]   <= '0;
              lvl_q[c]   <= '0;
            end else begin
              tmr_q[c] <= tmr_q[c] + 24'h000001;
            end
          end
          ST_LATCH: begin
            if (!conv_en[c]) begin
              state_q[c] <= ST_OFF; // RQ22
            end
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // rising status flags and interrupt
  logic [DATA_W-1:0] evt_bits;

  assign evt_bits = DATA_W'({latch_evt[CONV_LED], latch_evt[CONV_AUX]});

  // a new event in the clearing read cycle survives
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      flags_q <= FLAGS_RST;
    end else if (rd_flags) begin
      flags_q <= evt_bits; // RQ20
    end else begin
      flags_q <= flags_q | evt_bits; // RQ9
    end
  end

  assign o_interrupt_out_n = ~|(flags_q & ~mask_q); // RQ10

  ////////////////////////////////////////////////////////////////////////
  // read data
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rdata <= '0;
    end else if (i_rd) begin
      unique case (i_addr)
        ADDR_POWER_CTRL: o_rdata <= ctrl_q;
        ADDR_RISE_FLAGS: o_rdata <= flags_q;
        ADDR_RISE_MASK:  o_rdata <= mask_q;
        ADDR_DIM_LEVEL:  o_rdata <= dim_q;
        ADDR_SLOPE:      o_rdata <= {4'h0, slope_q};
        ADDR_AUX_VSEL:   o_rdata <= {5'h00, vsel_q};
        default:         o_rdata <= '0;
      endcase
    end else begin
      o_rdata <= '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // converter outputs
  assign o_aux_run = (state_q[CONV_AUX] == ST_SOFT) ||
                     (state_q[CONV_AUX] == ST_RUN);
  assign o_led_run = (state_q[CONV_LED] == ST_SOFT) ||
                     (state_q[CONV_LED] == ST_RUN); // RQ11
  assign o_aux_ss_level   = lvl_q[CONV_AUX];
  assign o_led_ss_level   = lvl_q[CONV_LED];
  assign o_aux_out_select = vsel_q;

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_aux_target_mv <= '0;
    end else begin
      o_aux_target_mv <= aux_mv(vsel_q); // RQ1
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // dimming source and dac
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_dim_source    <= DIM_SRC_ZERO;
      o_dac_numerator <= '0;
    end else begin
      o_dac_numerator <= dac_num(dim_q[DIM_CODE_W-1:0]); // RQ15
      if (dim_q[DIM_EN_BIT]) begin
        o_dim_source <= DIM_SRC_DAC; // RQ14
      end else if (sync2_q[SY_GATE]) begin
        o_dim_source <= DIM_SRC_PIN; // RQ13
      end else begin
        o_dim_source <= DIM_SRC_ZERO; // RQ12
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // slope compensation
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_low_slope_mv_us  <= '0;
      o_high_slope_mv_us <= '0;
      o_slope_mv_us      <= '0;
    end else begin
      o_low_slope_mv_us  <= slope_lo(slope_q[SLOPE_LO_LSB +: SLOPE_W]);
      o_high_slope_mv_us <= slope_hi(slope_q[SLOPE_HI_LSB +: SLOPE_W]);
      if (sync2_q[SY_DUTY]) begin
        o_slope_mv_us <= slope_hi(slope_q[SLOPE_HI_LSB +: SLOPE_W]); // RQ18
      end else begin
        o_slope_mv_us <= slope_lo(slope_q[SLOPE_LO_LSB +: SLOPE_W]); // RQ17
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // assertions
  a_sel_decode: assert property ( // RQ1
    @(posedge i_mclk) disable iff (!i_rst_n)
    (vsel_q == 3'h6) |=> (o_aux_target_mv == 16'h1c20)
  ) else $error("aux select decode wrong");

  a_sel_default: assert property ( // RQ2
    @(posedge i_mclk) disable iff (!i_rst_n)
    !sel_written_q |-> (vsel_q == VSEL_RST)
  ) else $error("aux select not at default");

  a_enable_gate: assert property ( // RQ4
    @(posedge i_mclk) disable iff (!i_rst_n)
    !ctrl_q[CTRL_AUX_BIT] |=> !o_aux_run
  ) else $error("aux runs while disabled");

  a_ramp_done: assert property ( // RQ5
    @(posedge i_mclk) disable iff (!i_rst_n)
    (state_q[CONV_AUX] == ST_SOFT ##1 state_q[CONV_AUX] == ST_RUN)
      |-> ($past(lvl_q[CONV_AUX]) == SS_FULL)
  ) else $error("run entered before ramp end");

  a_short_timeout: assert property ( // RQ6
    @(posedge i_mclk) disable iff (!i_rst_n)
    (state_q[CONV_AUX] == ST_RUN ##1 state_q[CONV_AUX] == ST_COOL)
      |-> ($past(tmr_q[CONV_AUX]) == TMR_W'(SC_DETECT_CYCLES - 1))
  ) else $error("short shutdown at wrong time");

  a_restart_time: assert property ( // RQ7
    @(posedge i_mclk) disable iff (!i_rst_n)
    (state_q[CONV_AUX] == ST_COOL ##1 state_q[CONV_AUX] == ST_SOFT)
      |-> ($past(tmr_q[CONV_AUX]) == TMR_W'(COOL_DOWN_CYCLES - 1))
  ) else $error("restart at wrong time");

  a_desat_latch: assert property ( // RQ8
    @(posedge i_mclk) disable iff (!i_rst_n)
    latch_evt[CONV_AUX] |=> (state_q[CONV_AUX] == ST_LATCH) &&
                            flags_q[FLAG_AUX_BIT]
  ) else $error("desat did not latch aux off"); // RQ9

  a_irq_pin: assert property ( // RQ10
    @(posedge i_mclk) disable iff (!i_rst_n)
    (flags_q[FLAG_AUX_BIT] && !mask_q[FLAG_AUX_BIT]) |-> !o_interrupt_out_n
  ) else $error("unmasked fault gives no interrupt");

  a_dim_select: assert property ( // RQ12
    @(posedge i_mclk) disable iff (!i_rst_n)
    (!dim_q[DIM_EN_BIT] && !sync2_q[SY_GATE]) |=>
      (o_dim_source == DIM_SRC_ZERO)
  ) else $error("gate low did not select zero level");

  a_dim_dac: assert property ( // RQ14
    @(posedge i_mclk) disable iff (!i_rst_n)
    dim_q[DIM_EN_BIT] |=> (o_dim_source == DIM_SRC_DAC)
  ) else $error("internal dim not selected");

  a_read_clear: assert property ( // RQ20
    @(posedge i_mclk) disable iff (!i_rst_n)
    (rd_flags && latch_evt == '0) |=> (flags_q == '0)
  ) else $error("flags not cleared by read");

  a_latch_hold: assert property ( // RQ22
    @(posedge i_mclk) disable iff (!i_rst_n)
    (state_q[CONV_LED] == ST_LATCH && conv_en[CONV_LED]) |=>
      (state_q[CONV_LED] == ST_LATCH)
  ) else $error("latched converter left latch");

endmodule : bdc_core

// ==== verif/bdc_host_model.sv ====
// host microcontroller model: drives the register port of bdc_core
// assumes one 125 mhz clock and the one-cycle strobe register port
`timescale 1ns/1ps
module bdc_host_model (
  // clock
  input  wire logic                       i_mclk,
  // register port
  output logic      [bdc_pkg::ADDR_W-1:0] o_addr,
  output logic      [bdc_pkg::DATA_W-1:0] o_wdata,
  output logic                            o_wr,
  output logic                            o_rd,
  input  wire logic [bdc_pkg::DATA_W-1:0] i_rdata
);
  import bdc_pkg::*;

  logic aux_on;

  initial begin
    o_addr  = 8'h00;
    o_wdata = 8'h00;
    o_wr    = 1'b0;
    o_rd    = 1'b0;
    aux_on  = 1'b0;
  end

  //////////////////////////////////////////////////////////////////////
  // one-cycle write; idle bus shows the inverse of the last value
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    if (a == ADDR_AUX_VSEL && aux_on) begin
      return;
    end
    @(posedge i_mclk);
    o_addr  <= a;
    o_wdata <= d;
    o_wr    <= 1'b1;
    @(posedge i_mclk);
    o_wr    <= 1'b0;
    o_addr  <= ~a;
    o_wdata <= ~d;
    if (a == ADDR_POWER_CTRL) aux_on = d[CTRL_AUX_BIT];
  endtask : wr

  //////////////////////////////////////////////////////////////////////
  // one-cycle read; data taken in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_mclk);
    o_addr <= a;
    o_rd   <= 1'b1;
    @(posedge i_mclk);
    o_rd   <= 1'b0;
    o_addr <= ~a;
    #1;
    d = i_rdata;
  endtask : rd

endmodule : bdc_host_model

// ==== verif/bdc_core_tb.sv ====
// self-checking testbench of bdc_core
// assumes bdc_pkg and bdc_host_model are compiled first
`timescale 1ns/1ps
module bdc_core_tb;
  import bdc_pkg::*;

  localparam int TIMEOUT_CYC = 6000;
  localparam logic [15:0] VSEL_MV [8] = '{16'h09c4, 16'h2710, 16'h1388,
    16'h3a98, 16'h0ce4, 16'h2ee0, 16'h1c20, 16'h5dc0};
  localparam logic [15:0] LO_MV [4] = '{16'h064, 16'h0c8, 16'h12c, 16'h190};
  localparam logic [15:0] HI_MV [4] = '{16'h12c, 16'h190, 16'h258, 16'h384};

  logic              i_mclk;
  logic              i_rst_n;
  logic [7:0]        addr;
  logic [7:0]        wdata;
  logic [7:0]        rdata;
  logic [7:0]        rd_val;
  logic              wr;
  logic              rd;
  logic              aux_uv;
  logic              led_uv;
  logic              aux_desat;
  logic              led_desat;
  logic              duty_high;
  logic              dim_gate;
  logic              aux_run;
  logic              led_run;
  logic [7:0]        aux_ss;
  logic [7:0]        led_ss;
  logic [2:0]        out_sel;
  logic [15:0]       target_mv;
  bdc_dim_src_e      dim_src;
  logic [7:0]        dac_num;
  logic [9:0]        lo_slope;
  logic [9:0]        hi_slope;
  logic [9:0]        slope;
  logic              intr_n;
  int                n_mismatch = 0;
  int                compares = 0;
  int                cyc_cnt = 0;

  bdc_host_model i_host (.i_mclk(i_mclk), .o_addr(addr), .o_wdata(wdata),
    .o_wr(wr), .o_rd(rd), .i_rdata(rdata));

  bdc_core #(.SC_DETECT_CYCLES(20), .COOL_DOWN_CYCLES(40),
    .SS_STEP_CYCLES(4)) i_dut (
    .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_aux_undervolt(aux_uv),
    .i_led_undervolt(led_uv), .i_aux_desat(aux_desat),
    .i_led_desat(led_desat), .i_led_duty_high(duty_high),
    .i_dim_gate(dim_gate), .o_aux_run(aux_run), .o_aux_ss_level(aux_ss),
    .o_aux_out_select(out_sel), .o_aux_target_mv(target_mv),
    .o_led_run(led_run), .o_led_ss_level(led_ss), .o_dim_source(dim_src),
    .o_dac_numerator(dac_num), .o_low_slope_mv_us(lo_slope),
    .o_high_slope_mv_us(hi_slope), .o_slope_mv_us(slope),
    .o_interrupt_out_n(intr_n));

  //////////////////////////////////////////////////////////////////////
  // shared tasks
  task automatic chk(input string name, input logic [15:0] seen,
                     input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %s expected %0h seen %0h", name, exp, seen);
    end
  endtask : chk

  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp,
                       input string name);
    i_host.rd(a, rd_val);
    chk(name, {8'h00, rd_val}, {8'h00, exp});
  endtask : rdchk

  task automatic cyc(input int n);
    repeat (n) @(posedge i_mclk);
    #1;
  endtask : cyc

  task automatic print_verdict;
    $display("compares %0d n_mismatch %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : print_verdict

  //////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_reset;
    cyc(3);
    chk("target_mv", target_mv, 16'h1388);
    chk("low_slope", {6'h00, lo_slope}, 16'h064);
    chk("high_slope", {6'h00, hi_slope}, 16'h12c);
    chk("intr_n", {15'h0000, intr_n}, 16'h0001);
    rdchk(ADDR_AUX_VSEL, 8'h02, "vsel");
    rdchk(ADDR_SLOPE, 8'h00, "slope_reg");
    rdchk(ADDR_POWER_CTRL, 8'h00, "ctrl");
    rdchk(8'h30, 8'h00, "unmapped");
  endtask : t_reset

  task automatic t_vsel;
    for (int i = 0; i < 8; i++) begin
      i_host.wr(ADDR_AUX_VSEL, 8'(i));
      cyc(2);
      chk("target_mv", target_mv, VSEL_MV[i]);
      chk("out_sel", {13'h0000, out_sel}, 16'(i));
    end
    i_host.wr(ADDR_AUX_VSEL, 8'h02);
  endtask : t_vsel

  task automatic t_slope;
    for (int i = 0; i < 4; i++) begin
      i_host.wr(ADDR_SLOPE, 8'(i + 4 * (3 - i)));
      @(posedge i_mclk);
      duty_high <= 1'b1;
      cyc(6);
      chk("low_slope", {6'h00, lo_slope}, LO_MV[i]);
      chk("high_slope", {6'h00, hi_slope}, HI_MV[3 - i]);
      chk("slope_hi", {6'h00, slope}, HI_MV[3 - i]);
      @(posedge i_mclk);
      duty_high <= 1'b0;
      cyc(6);
      chk("slope_lo", {6'h00, slope}, LO_MV[i]);
    end
  endtask : t_slope

  task automatic t_dim;
    cyc(5);
    chk("dim_zero", {14'h0000, dim_src}, {14'h0000, DIM_SRC_ZERO});
    @(posedge i_mclk);
    dim_gate <= 1'b1;
    cyc(6);
    chk("dim_pin", {14'h0000, dim_src}, {14'h0000, DIM_SRC_PIN});
    i_host.wr(ADDR_DIM_LEVEL, 8'h80);
    cyc(3);
    chk("dim_dac", {14'h0000, dim_src}, {14'h0000, DIM_SRC_DAC});
    chk("dac_num", {8'h00, dac_num}, 16'h0001);
    @(posedge i_mclk);
    dim_gate <= 1'b0;
    i_host.wr(ADDR_DIM_LEVEL, 8'hff);
    cyc(6);
    chk("dim_dac", {14'h0000, dim_src}, {14'h0000, DIM_SRC_DAC});
    chk("dac_num", {8'h00, dac_num}, 16'h0080);
    i_host.wr(ADDR_DIM_LEVEL, 8'h7f);
    cyc(3);
    chk("dim_zero", {14'h0000, dim_src}, {14'h0000, DIM_SRC_ZERO});
  endtask : t_dim

  task automatic t_enable;
    i_host.wr(ADDR_POWER_CTRL, 8'h03);
    cyc(3);
    chk("aux_run", {15'h0000, aux_run}, 16'h0001);
    chk("led_run", {15'h0000, led_run}, 16'h0001);
    cyc(250);
    chk("aux_ss", {8'h00, aux_ss}, 16'h003f);
    cyc(500);
    chk("aux_ss", {8'h00, aux_ss}, 16'h00bc);
    chk("led_ss", {8'h00, led_ss}, 16'h00bc);
    i_host.wr(ADDR_POWER_CTRL, 8'h01);
    cyc(3);
    chk("led_run", {15'h0000, led_run}, 16'h0000);
    i_host.wr(ADDR_POWER_CTRL, 8'h03);
  endtask : t_enable

  task automatic t_short;
    i_host.wr(ADDR_POWER_CTRL, 8'h02);
    i_host.wr(ADDR_POWER_CTRL, 8'h03);
    cyc(1030);
    chk("aux_ss", {8'h00, aux_ss}, {8'h00, SS_FULL});
    @(posedge i_mclk);
    aux_uv <= 1'b1;
    cyc(10);
    chk("aux_uv_run", {15'h0000, aux_run}, 16'h0001);
    cyc(15);
    chk("aux_short", {15'h0000, aux_run}, 16'h0000);
    chk("led_run", {15'h0000, led_run}, 16'h0001);
    @(posedge i_mclk);
    aux_uv <= 1'b0;
    cyc(33);
    chk("aux_cool", {15'h0000, aux_run}, 16'h0000);
    cyc(4);
    chk("aux_restart", {15'h0000, aux_run}, 16'h0001);
    chk("aux_ss", {8'h00, aux_ss}, 16'h0000);
  endtask : t_short

  task automatic t_fault;
    @(posedge i_mclk);
    aux_desat <= 1'b1;
    cyc(5);
    chk("aux_run", {15'h0000, aux_run}, 16'h0000);
    chk("led_run", {15'h0000, led_run}, 16'h0001);
    chk("intr_n", {15'h0000, intr_n}, 16'h0000);
    @(posedge i_mclk);
    aux_desat <= 1'b0;
    cyc(5);
    chk("aux_latched", {15'h0000, aux_run}, 16'h0000);
    rdchk(ADDR_RISE_FLAGS, 8'h01, "flags");
    rdchk(ADDR_RISE_FLAGS, 8'h00, "flags_clr");
    chk("intr_n", {15'h0000, intr_n}, 16'h0001);
    i_host.wr(ADDR_POWER_CTRL, 8'h02);
    i_host.wr(ADDR_POWER_CTRL, 8'h03);
    i_host.wr(ADDR_RISE_MASK, 8'h01);
    cyc(3);
    chk("aux_rerun", {15'h0000, aux_run}, 16'h0001);
    @(posedge i_mclk);
    aux_desat <= 1'b1;
    cyc(5);
    chk("aux_run", {15'h0000, aux_run}, 16'h0000);
    chk("intr_masked", {15'h0000, intr_n}, 16'h0001);
    @(posedge i_mclk);
    led_desat <= 1'b1;
    cyc(5);
    chk("led_run", {15'h0000, led_run}, 16'h0000);
    chk("intr_n", {15'h0000, intr_n}, 16'h0000);
    rdchk(ADDR_RISE_FLAGS, 8'h03, "flags");
  endtask : t_fault

  //////////////////////////////////////////////////////////////////////
  // clock, timeout and main sequence
  initial begin
    i_mclk = 1'b0;
    forever #4 i_mclk = ~i_mclk;
  end

  always @(posedge i_mclk) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == TIMEOUT_CYC) begin
      n_mismatch++;
      print_verdict();
    end
  end

  initial begin
    i_rst_n   = 1'b0;
    aux_uv    = 1'b0;
    led_uv    = 1'b0;
    aux_desat = 1'b0;
    led_desat = 1'b0;
    duty_high = 1'b0;
    dim_gate  = 1'b0;
    repeat (6) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    t_reset();
    t_vsel();
    t_slope();
    t_dim();
    t_enable();
    t_short();
    t_fault();
    print_verdict();
  end

endmodule : bdc_core_tb
